// [spio_pkg.sv]
package spio_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] SPIO_OFS_LATCH_A = 4'h0;
  localparam logic [3:0] SPIO_OFS_LATCH_B = 4'h1;
  localparam logic [3:0] SPIO_OFS_LATCH_C = 4'h2;
  localparam logic [3:0] SPIO_OFS_LATCH_D = 4'h3;
  localparam logic [3:0] SPIO_OFS_DIR_A = 4'h4;
  localparam logic [3:0] SPIO_OFS_DIR_B = 4'h5;
  localparam logic [3:0] SPIO_OFS_DIR_C = 4'h6;
  localparam logic [3:0] SPIO_OFS_DIR_D = 4'h7;
  localparam logic [3:0] SPIO_OFS_LATCH_E = 4'h8;
  localparam logic [3:0] SPIO_OFS_LATCH_F = 4'h9;
  localparam logic [3:0] SPIO_OFS_DIR_E = 4'hC;
  localparam logic [3:0] SPIO_OFS_DIR_F = 4'hD;

  // ---------------------------------------------------------------
  // implemented bits per port, reset values, field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] SPIO_MASK_A = 8'hFF;
  localparam logic [7:0] SPIO_MASK_B = 8'hFF;
  localparam logic [7:0] SPIO_MASK_C = 8'h1F;
  localparam logic [7:0] SPIO_MASK_D = 8'h7F;
  localparam logic [7:0] SPIO_MASK_E = 8'hFF;
  localparam logic [7:0] SPIO_MASK_F = 8'h0F;
  localparam logic [7:0] SPIO_DIR_RESET = 8'h00;
  localparam logic [7:0] SPIO_RDATA_RESET = 8'h00;
  localparam int SPIO_CLKOUT_EN_BIT = 7;
  localparam int SPIO_CLKOUT_PIN = 2;
  localparam int SPIO_PORTS = 6;

  // one port's pin bundle toward the pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } spio_pad_t;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spio_req_t;

endpackage

// [six_port_parallel_io.sv]
`timescale 1ns/1ns

// Behaviour
// - forty pins in six ports, each pin individually input or output
// - port A has eight data latches untouched by reset
// - port A direction 1 drives the pin, 0 leaves it high impedance
// - reset clears port A direction bits to input
// - port A read gives latch for outputs, pin level for inputs
// - data writes always load the latch, whatever the direction
// - port B has eight data latches untouched by reset
// - port B direction 1 drives the pin; reset clears to input
// - converter channel select decides which port B pin is a converter input
// - converter pin read gives 0 as input, latch as output
// - converter pins never drive; direction still picks latch or zero
// - register offsets 0x0-0x9, 0xC, 0xD as mapped
// - ports C, D, F implement 5, 7, 4 bits; rest read zero
// - port C direction bit 7 is bus clock output enable
// - enable set drives bus clock on port C pin 2; reset clears it
module spio_six_port_parallel_io (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register bus
  input wire spio_pkg::spio_req_t busReq,
  output logic [7:0] busRdata,
  // converter channel select
  input wire logic [4:0] convChanSel,
  // bus clock to put out on port C pin 2
  input wire logic busClk,
  // pads, ports A to F
  input wire logic [7:0] padIn [spio_pkg::SPIO_PORTS],
  output spio_pkg::spio_pad_t pads [spio_pkg::SPIO_PORTS]
);
  import spio_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstSync1_r;
  logic rstSync2_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  wire rstn = rstSync2_r;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  localparam logic [7:0] IMPL [SPIO_PORTS] = '{SPIO_MASK_A, SPIO_MASK_B, SPIO_MASK_C,
                                               SPIO_MASK_D, SPIO_MASK_E, SPIO_MASK_F};
  localparam logic [3:0] LOFS [SPIO_PORTS] = '{SPIO_OFS_LATCH_A, SPIO_OFS_LATCH_B, SPIO_OFS_LATCH_C,
                                               SPIO_OFS_LATCH_D, SPIO_OFS_LATCH_E, SPIO_OFS_LATCH_F};
  localparam logic [3:0] DOFS [SPIO_PORTS] = '{SPIO_OFS_DIR_A, SPIO_OFS_DIR_B, SPIO_OFS_DIR_C,
                                               SPIO_OFS_DIR_D, SPIO_OFS_DIR_E, SPIO_OFS_DIR_F};

  logic [7:0] latch_r [SPIO_PORTS];
  logic [7:0] dir_r [SPIO_PORTS];
  logic clkOutEn_r;
  logic [7:0] convUse;
  logic [7:0] rdNxt;
  logic [7:0] busRdata_r;

  // converter owns one port B pin when the select names channels 0..7
  always_comb begin
    convUse = 8'h00;
    if (convChanSel < 5'h08) begin
      convUse[convChanSel[2:0]] = 1'b1;
    end
  end

  // latches have no reset: they keep their contents across it
  genvar g;
  generate
    for (g = 0; g < SPIO_PORTS; g++) begin : gPort
      always_ff @(posedge core_clk) begin
        if (busReq.wr && busReq.addr == LOFS[g]) begin
          latch_r[g] <= busReq.wdata & IMPL[g];
        end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          dir_r[g] <= SPIO_DIR_RESET;
        end else if (busReq.wr && busReq.addr == DOFS[g]) begin
          dir_r[g] <= busReq.wdata & IMPL[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clkOutEn_r <= 1'b0;
    end else if (busReq.wr && busReq.addr == SPIO_OFS_DIR_C) begin
      clkOutEn_r <= busReq.wdata[SPIO_CLKOUT_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // pad drive
  // ---------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < SPIO_PORTS; p++) begin
      pads[p].out = latch_r[p];
      pads[p].oe = dir_r[p];
    end
    pads[1].oe = dir_r[1] & ~convUse;
    if (clkOutEn_r) begin
      pads[2].out[SPIO_CLKOUT_PIN] = busClk;
      pads[2].oe[SPIO_CLKOUT_PIN] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdNxt = 8'h00; // unmapped offsets read zero
    for (int p = 0; p < SPIO_PORTS; p++) begin
      if (busReq.addr == LOFS[p]) begin
        rdNxt = ((dir_r[p] & latch_r[p]) | (~dir_r[p] & padIn[p])) & IMPL[p];
      end
      if (busReq.addr == DOFS[p]) begin
        rdNxt = dir_r[p];
      end
    end
    if (busReq.addr == SPIO_OFS_LATCH_B) begin
      rdNxt = (dir_r[1] & latch_r[1]) | (~dir_r[1] & ~convUse & padIn[1]);
    end
    if (busReq.addr == SPIO_OFS_DIR_C) begin
      rdNxt[SPIO_CLKOUT_EN_BIT] = clkOutEn_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busRdata_r <= SPIO_RDATA_RESET;
    end else if (busReq.rd) begin
      busRdata_r <= rdNxt;
    end else begin
      busRdata_r <= SPIO_RDATA_RESET;
    end
  end
  assign busRdata = busRdata_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  dir_a_reset_a: assert property (@(posedge core_clk) $rose(rstn) |-> dir_r[0] == 8'h00)
    else $error("port A direction not cleared by reset");
  a_drive_a: assert property (@(posedge core_clk) disable iff (!rstn) pads[0].oe == dir_r[0])
    else $error("port A enable differs from direction");
  a_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      busReq.rd && busReq.addr == SPIO_OFS_LATCH_A |=>
      busRdata == $past((dir_r[0] & latch_r[0]) | (~dir_r[0] & padIn[0])))
    else $error("port A read mismatch");
  latch_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      busReq.wr && busReq.addr == SPIO_OFS_LATCH_A |=> latch_r[0] == $past(busReq.wdata))
    else $error("port A latch not loaded");
  conv_nodrive_a: assert property (@(posedge core_clk) disable iff (!rstn) (pads[1].oe & convUse) == 8'h00)
    else $error("converter pin driven");
  conv_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      busReq.rd && busReq.addr == SPIO_OFS_LATCH_B |=> (busRdata & ~$past(dir_r[1]) & $past(convUse)) == 8'h00)
    else $error("converter input pin read nonzero");
  unimpl_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
      busReq.rd && busReq.addr == SPIO_OFS_LATCH_F |=> busRdata[7:4] == 4'h0)
    else $error("port F upper bits nonzero");
  clk_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
      clkOutEn_r |-> pads[2].oe[2] && pads[2].out[2] == busClk)
    else $error("bus clock not driven on port C pin 2");
  dir_b_reset_a: assert property (@(posedge core_clk) $rose(rstn) |-> dir_r[1] == 8'h00 && !clkOutEn_r)
    else $error("port B direction or clock enable not cleared");

endmodule

// [spio_board_model.sv]
`timescale 1ns/1ns
module spio_board_model (
  // pads of the block
  input wire spio_pkg::spio_pad_t pads [spio_pkg::SPIO_PORTS],
  // levels the board puts on pins the block leaves undriven
  input wire logic [7:0] boardLvl [spio_pkg::SPIO_PORTS],
  // pin levels back to the block
  output logic [7:0] padIn [spio_pkg::SPIO_PORTS]
);
  import spio_pkg::*;
  // driven pins show the block's level, undriven ones the board's
  always_comb begin
    for (int p = 0; p < SPIO_PORTS; p++) begin
      padIn[p] = (pads[p].out & pads[p].oe) | (boardLvl[p] & ~pads[p].oe);
    end
  end
endmodule

// [six_port_parallel_io_tb_top.sv]
`timescale 1ns/1ns
module six_port_parallel_io_tb_top;
  import spio_pkg::*;
  logic core_clk, resetn, busClk;
  spio_req_t busReq;
  logic [7:0] busRdata;
  logic [4:0] convChanSel;
  logic [7:0] padIn [SPIO_PORTS];
  logic [7:0] boardLvl [SPIO_PORTS];
  spio_pad_t pads [SPIO_PORTS];
  int nFail, nChecks;
  logic [3:0] latOfs [6] = '{SPIO_OFS_LATCH_A, SPIO_OFS_LATCH_B, SPIO_OFS_LATCH_C, SPIO_OFS_LATCH_D,
    SPIO_OFS_LATCH_E, SPIO_OFS_LATCH_F};
  logic [3:0] dirOfs [6] = '{SPIO_OFS_DIR_A, SPIO_OFS_DIR_B, SPIO_OFS_DIR_C, SPIO_OFS_DIR_D,
    SPIO_OFS_DIR_E, SPIO_OFS_DIR_F};
  logic [7:0] msk [6] = '{SPIO_MASK_A, SPIO_MASK_B, SPIO_MASK_C, SPIO_MASK_D, SPIO_MASK_E, SPIO_MASK_F};

  spio_six_port_parallel_io spio_six_port_parallel_io_i (.core_clk(core_clk), .resetn(resetn),
    .busReq(busReq), .busRdata(busRdata), .convChanSel(convChanSel), .busClk(busClk),
    .padIn(padIn), .pads(pads));
  spio_board_model spio_board_model_i (.pads(pads), .boardLvl(boardLvl), .padIn(padIn));

  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 chk(name, exp, busRdata);
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clocks, watchdog, tests
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) busClk <= ~busClk;
  initial begin
    repeat (3000) @(posedge core_clk);
    nFail++;
    end_sim();
  end
  initial begin
    busReq = '0;
    resetn = 1'b0;
    busClk = 1'b0;
    convChanSel = 5'h1F;
    nFail = 0;
    nChecks = 0;
    foreach (boardLvl[p]) boardLvl[p] = 8'h3C;
    do_reset();
    for (int p = 0; p < 6; p++) begin
      rchk("dir reset", dirOfs[p], 8'h00);
      chk("oe reset", 8'h00, pads[p].oe);
    end
    $display("test reset done");
    for (int p = 0; p < 6; p++) begin
      wr(latOfs[p], 8'hFF);
      wr(dirOfs[p], 8'hFF);
      rchk("latch mask", latOfs[p], msk[p]);
      rchk("dir mask", dirOfs[p], msk[p] | (p == 2 ? 8'h80 : 8'h00));
      chk("oe mask", msk[p], pads[p].oe);
    end
    wr(4'hA, 8'hFF);
    rchk("unmapped", 4'hA, 8'h00);
    wr(SPIO_OFS_DIR_C, 8'h80);
    #1 chk("clock pin oe", 8'h04, pads[2].oe);
    $display("test map done");
    wr(SPIO_OFS_LATCH_A, 8'hA5);
    wr(SPIO_OFS_DIR_A, 8'h0F);
    rchk("port a mixed", SPIO_OFS_LATCH_A, 8'h35);
    chk("port a oe", 8'h0F, pads[0].oe);
    chk("port a out", 8'h05, pads[0].out & pads[0].oe);
    wr(SPIO_OFS_LATCH_A, 8'h5A);
    rchk("latch under input", SPIO_OFS_LATCH_A, 8'h3A);
    $display("test port a done");
    @(posedge core_clk);
    convChanSel <= 5'h03;
    wr(SPIO_OFS_LATCH_B, 8'h5A);
    wr(SPIO_OFS_DIR_B, 8'hF0);
    rchk("conv input", SPIO_OFS_LATCH_B, 8'h54);
    chk("conv oe in", 8'hF0, pads[1].oe);
    wr(SPIO_OFS_DIR_B, 8'hFF);
    rchk("conv output", SPIO_OFS_LATCH_B, 8'h5A);
    chk("conv oe", 8'hF7, pads[1].oe);
    @(posedge core_clk);
    convChanSel <= 5'h08;
    @(posedge core_clk);
    #1 chk("no conv oe", 8'hFF, pads[1].oe);
    $display("test port b done");
    do_reset();
    rchk("dir a again", SPIO_OFS_DIR_A, 8'h00);
    wr(SPIO_OFS_DIR_A, 8'hFF);
    wr(SPIO_OFS_DIR_B, 8'hFF);
    rchk("latch a kept", SPIO_OFS_LATCH_A, 8'h5A);
    rchk("latch b kept", SPIO_OFS_LATCH_B, 8'h5A);
    $display("test second reset done");
    end_sim();
  end
endmodule
